// ==== design/dswl_device.sv ====
// Behaviour
// - Async words framed by start 0, stop 1.
// - Bit cells are sixteen clocks long.
// - Sample MSB at clock 24, then every 16.
// - Sender holds line high between words.
// - Good stop bit updates converter value.
// - Bad stop bit gives serial_out pulse one serial clock period long.
// - Framing error discards word, value kept.
// - Static high load_strobe selects async mode.
// - Three-wire shifts, load_strobe pulse transfers.
// - Host keeps load_strobe low while shifting.
// - Host keeps clock low during load.
// - Loop fault is active-low open drain.
// - Second-order modulator makes one-bit stream.
// - Three-wire shift on rising serial clock.
// - Three-wire serial_out carries bits leaving shift register.
`timescale 1ns/1ns
module dswl_device (
  input wire logic clk,
  input wire logic resetn,
  dswl_if.device link,
  input wire logic compliance_near,
  output logic [15:0] dac_value_q,
  output logic mod_bit_q,
  output logic frame_error_q
);
  localparam int unsigned W = dswl_pkg::WORD_W;
  localparam int unsigned MOD_W = dswl_pkg::MOD_W;
  logic [2:0] clk_s_q, din_s_q, ls_s_q;
  logic clk_rise, mode_async;
  logic [W-1:0] shift_q;
  logic [W-1:0] rx_q;
  logic [dswl_pkg::CNT_W-1:0] cnt_q;
  dswl_pkg::dswl_rx_t rx_state_q;
  logic din_prev_q, ls_prev_q, so_q;
  logic [dswl_pkg::MOD_W-1:0] int1_q, int2_q;

  // Three-stage synchronisers; only stages 1 and 2 are used for decisions.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_s_q <= 3'h0;
      din_s_q <= 3'h7;
      ls_s_q <= 3'h0;
    end else begin
      clk_s_q <= {clk_s_q[1:0], link.serial_clk};
      din_s_q <= {din_s_q[1:0], link.serial_in};
      ls_s_q <= {ls_s_q[1:0], link.load_strobe};
    end
  end

  assign clk_rise = clk_s_q[1] && !clk_s_q[2];

  // A strobe that stays high for more than 17 serial clock rises is taken as the async strap.
  logic [dswl_pkg::CNT_W-1:0] ls_high_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ls_high_q <= '0;
      ls_prev_q <= 1'b0;
    end else begin
      ls_prev_q <= ls_s_q[2];
      if (!ls_s_q[2]) ls_high_q <= '0;
      else if (clk_rise && ls_high_q != '1) ls_high_q <= ls_high_q + 1'b1;
    end
  end
  assign mode_async = ls_high_q > dswl_pkg::CNT_W'(W + 1);

  // Three-wire shift register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
    end else if (clk_rise && !mode_async) begin
      shift_q <= {shift_q[W-2:0], din_s_q[2]};
    end
  end

  // Async receiver.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_q <= dswl_pkg::DSWL_IDLE;
      cnt_q <= '0;
      rx_q <= '0;
      din_prev_q <= 1'b1;
    end else if (clk_rise) begin
      din_prev_q <= din_s_q[2];
      case (rx_state_q)
        dswl_pkg::DSWL_IDLE: begin
          cnt_q <= '0;
          if (mode_async && din_prev_q && !din_s_q[2]) begin
            rx_state_q <= dswl_pkg::DSWL_FRAME;
            cnt_q <= dswl_pkg::CNT_W'(1);
          end
        end
        dswl_pkg::DSWL_FRAME: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= dswl_pkg::CNT_W'(dswl_pkg::MSB_SAMPLE)
              && cnt_q < dswl_pkg::CNT_W'(dswl_pkg::STOP_SAMPLE)
              && cnt_q[3:0] == 4'h8) begin
            rx_q <= {rx_q[W-2:0], din_s_q[2]};
          end
          if (cnt_q == dswl_pkg::CNT_W'(dswl_pkg::STOP_SAMPLE)) begin
            rx_state_q <= dswl_pkg::DSWL_IDLE;
          end
        end
        default: rx_state_q <= dswl_pkg::DSWL_IDLE;
      endcase
    end
  end

  logic stop_now;
  assign stop_now = clk_rise && rx_state_q == dswl_pkg::DSWL_FRAME
    && cnt_q == dswl_pkg::CNT_W'(dswl_pkg::STOP_SAMPLE);

  // Converter value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_value_q <= dswl_pkg::DAC_RESET;
    end else if (stop_now && din_s_q[2]) begin
      dac_value_q <= rx_q;
    end else if (!mode_async && ls_s_q[2] && !ls_prev_q) begin
      dac_value_q <= shift_q;
    end
  end

  // Framing error pulse lasts one serial clock period.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_error_q <= 1'b0;
    end else if (stop_now) begin
      frame_error_q <= !din_s_q[2];
    end else if (clk_rise) begin
      frame_error_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) so_q <= 1'b0;
    else if (mode_async) so_q <= (stop_now && !din_s_q[2]) || (frame_error_q && !clk_rise);
    else so_q <= shift_q[W-1];
  end
  assign link.serial_out = so_q;

  // Second-order error-feedback modulator over the converter value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int1_q <= '0;
      int2_q <= '0;
      mod_bit_q <= 1'b0;
    end else begin
      int1_q <= int1_q + MOD_W'(dac_value_q) - (mod_bit_q ? MOD_W'(20'h10000) : '0);
      int2_q <= int2_q + int1_q - (mod_bit_q ? MOD_W'(20'h10000) : '0);
      mod_bit_q <= !int2_q[dswl_pkg::MOD_W-1] && int2_q != '0;
    end
  end

  // Open drain: only ever pulls low.
  logic fault_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) fault_q <= 1'b0;
    else fault_q <= compliance_near;
  end
  assign link.loop_fault_n_o = 1'b0;
  assign link.loop_fault_n_oe = fault_q;
endmodule // dswl_device

// ==== inc/dswl_pkg.sv ====
package dswl_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CELL_CLKS = 16;
  localparam int unsigned MSB_SAMPLE = 24;
  localparam int unsigned STOP_SAMPLE = MSB_SAMPLE + WORD_W * CELL_CLKS;
  localparam int unsigned CNT_W = 9;
  localparam logic [WORD_W-1:0] DAC_RESET = 16'h0000;
  localparam int unsigned SCLK_DIV = 8;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned MOD_W = 20;
  typedef enum logic [1:0] {DSWL_IDLE, DSWL_FRAME} dswl_rx_t;
  typedef enum logic [2:0] {DSWL_H_IDLE, DSWL_H_LO, DSWL_H_HI, DSWL_H_LATCH,
                            DSWL_H_ASYNC} dswl_host_t;
endpackage

// ==== inc/dswl_if.sv ====
`timescale 1ns/1ns
interface dswl_if;
  logic serial_clk;
  logic serial_in;
  logic load_strobe;
  logic serial_out;
  logic loop_fault_n_o;
  logic loop_fault_n_oe;
  modport device (input serial_clk, input serial_in, input load_strobe, output serial_out,
    output loop_fault_n_o, output loop_fault_n_oe);
  modport host (output serial_clk, output serial_in, output load_strobe, input serial_out,
    input loop_fault_n_o, input loop_fault_n_oe);
endinterface

// ==== design/dswl_host.sv ====
`timescale 1ns/1ns
module dswl_host (
  input wire logic clk,
  input wire logic resetn,
  dswl_if.host link,
  input wire logic async_mode,
  input wire logic send_valid,
  input wire logic [15:0] send_word,
  output logic send_ready_q,
  output logic fault_seen_q
);
  localparam int unsigned W = dswl_pkg::WORD_W;
  dswl_pkg::dswl_host_t st_q;
  logic [dswl_pkg::DIV_W-1:0] div_q;
  logic [8:0] bits_q;
  logic [17:0] sh_q;
  logic sclk_q, din_q, ls_q;
  logic half;
  assign half = div_q == dswl_pkg::DIV_W'(dswl_pkg::SCLK_DIV - 1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) div_q <= '0;
    else div_q <= half ? '0 : div_q + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= dswl_pkg::DSWL_H_IDLE;
      sclk_q <= 1'b0;
      din_q <= 1'b1;
      ls_q <= 1'b0;
      sh_q <= '1;
      bits_q <= '0;
      send_ready_q <= 1'b0;
    end else begin
      send_ready_q <= 1'b0;
      if (async_mode) begin
        ls_q <= 1'b1;
        if (half) sclk_q <= !sclk_q;
      end
      case (st_q)
        dswl_pkg::DSWL_H_IDLE: begin
          din_q <= 1'b1;
          if (!async_mode) ls_q <= 1'b0;
          if (send_valid && half && !sclk_q) begin
            send_ready_q <= 1'b1;
            bits_q <= '0;
            if (async_mode) begin
              sh_q <= {1'b0, send_word, 1'b1};
              st_q <= dswl_pkg::DSWL_H_ASYNC;
            end else begin
              sh_q <= {2'b11, send_word};
              st_q <= dswl_pkg::DSWL_H_LO;
            end
          end
        end
        dswl_pkg::DSWL_H_LO: if (half) begin
          ls_q <= 1'b0;
          din_q <= sh_q[W-1];
          sh_q <= {sh_q[16:0], 1'b1};
          st_q <= dswl_pkg::DSWL_H_HI;
        end
        dswl_pkg::DSWL_H_HI: if (half) begin
          sclk_q <= ~sclk_q;
          if (sclk_q) begin
            if (bits_q == 9'(W - 1)) st_q <= dswl_pkg::DSWL_H_LATCH;
            else st_q <= dswl_pkg::DSWL_H_LO;
            bits_q <= bits_q + 1'b1;
          end
        end
        dswl_pkg::DSWL_H_LATCH: if (half) begin
          ls_q <= 1'b1;
          st_q <= dswl_pkg::DSWL_H_IDLE;
        end
        // Data moves on the falling serial clock so that it is settled at the sampling rise.
        dswl_pkg::DSWL_H_ASYNC: if (half && sclk_q) begin
          bits_q <= bits_q + 1'b1;
          if (bits_q[3:0] == 4'h0) begin
            din_q <= sh_q[17];
            sh_q <= {sh_q[16:0], 1'b1};
          end
          if (bits_q == 9'h130) st_q <= dswl_pkg::DSWL_H_IDLE;
        end
        default: st_q <= dswl_pkg::DSWL_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) fault_seen_q <= 1'b0;
    else fault_seen_q <= link.loop_fault_n_oe;
  end

  assign link.serial_clk = sclk_q;
  assign link.serial_in = din_q;
  assign link.load_strobe = ls_q;
endmodule // dswl_host

// ==== dv/dswl_link_assertions.sv ====
`timescale 1ns/1ns
module dswl_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic serial_out,
  input wire logic loop_fault_n_o,
  input wire logic loop_fault_n_oe
);
  logic [15:0] run_q;
  logic [15:0] ld_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Serial clock rises since the data line last moved; cell lengths are judged on it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) run_q <= 16'h0000;
    else if ($changed(serial_in)) run_q <= 16'h0000;
    else if ($rose(serial_clk)) run_q <= run_q + 16'h0001;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ld_q <= 16'h0000;
    else if ($fell(load_strobe)) ld_q <= 16'h0000;
    else if ($rose(serial_clk)) ld_q <= ld_q + 16'h0001;
  end
  a_fault_open_drain: assert property (loop_fault_n_oe |-> !loop_fault_n_o)
    else $error("fault pin driven high");
  a_data_clock_low: assert property ($changed(serial_in) |-> !serial_clk)
    else $error("data moved while serial clock high");
  a_clock_high_time: assert property ($rose(serial_clk) |-> serial_clk [*8] ##1 !serial_clk)
    else $error("serial clock high phase wrong");
  a_cell_whole: assert property ($rose(serial_in) && load_strobe |-> run_q[3:0] == 4'h0)
    else $error("async low run not whole cells");
  a_stop_in_time: assert property ($rose(serial_in) && load_strobe |-> run_q <= 16'h0110)
    else $error("stop bit missing");
  a_load_after_word: assert property ($rose(load_strobe) |-> ld_q inside {16'h0000, 16'h0010})
    else $error("load not after whole word");
  a_load_clk_low: assert property ($rose(load_strobe) |-> !serial_clk)
    else $error("clock high at load");
  a_unload_clk_low: assert property ($fell(load_strobe) |-> !serial_clk && !$past(serial_clk))
    else $error("clock high during load");
  cover property ($rose(load_strobe));
  cover property ($rose(serial_in) && load_strobe && run_q == 16'h0110);
  cover property ($rose(loop_fault_n_oe));
  cover property ($rose(serial_out));
endmodule // dswl_chk

// ==== dv/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic async_mode = 1'b0;
  logic send_valid = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic near = 1'b0;
  logic send_ready_q;
  logic [15:0] dac_value_q;
  logic [15:0] dac_b;
  logic [15:0] so_q;
  int hi_n = 0;
  int n_mismatch = 0;
  int compares = 0;
  dswl_if link();
  dswl_if link_b();
  dswl_host u_dswl_host (.clk(clk), .resetn(resetn), .link(link), .async_mode(async_mode),
    .send_valid(send_valid), .send_word(send_word), .send_ready_q(send_ready_q),
    .fault_seen_q());
  dswl_device u_dswl_device (.clk(clk), .resetn(resetn), .link(link), .compliance_near(near),
    .dac_value_q(dac_value_q), .mod_bit_q(), .frame_error_q());
  // The second device faces the bench, so that bad frames can be sent on purpose.
  dswl_device u_dswl_device_b (.clk(clk), .resetn(resetn), .link(link_b),
    .compliance_near(1'b0), .dac_value_q(dac_b), .mod_bit_q(), .frame_error_q());
  dswl_chk u_dswl_chk (.clk(clk), .resetn(resetn), .serial_clk(link.serial_clk),
    .serial_in(link.serial_in), .load_strobe(link.load_strobe), .serial_out(link.serial_out),
    .loop_fault_n_o(link.loop_fault_n_o), .loop_fault_n_oe(link.loop_fault_n_oe));
  always #5 clk = ~clk;
  always @(posedge link.serial_clk) so_q <= {so_q[14:0], link.serial_out};
  always @(negedge clk) if (link_b.serial_out === 1'b1) hi_n++;
  initial begin
    link_b.serial_clk = 1'b0;
    #10;
    forever #80 link_b.serial_clk = ~link_b.serial_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic mode, input logic [15:0] word);
    @(negedge clk);
    // The device needs a run of strobe-high clocks before it treats the strap as async mode.
    if (mode && !async_mode) begin
      async_mode = mode;
      repeat (384) @(negedge clk);
    end
    async_mode = mode;
    send_word = word;
    send_valid = 1'b1;
    for (int i = 0; i < 9000 && send_ready_q !== 1'b1; i++) @(negedge clk);
    send_valid = 1'b0;
    for (int i = 0; i < 9000 && dac_value_q !== word; i++) @(negedge clk);
  endtask
  task automatic send_b(input logic [15:0] word, input logic stop);
    logic [18:0] bits;
    bits = {1'b0, word, stop, 1'b1};
    for (int i = 18; i >= 0; i--) begin
      @(negedge link_b.serial_clk);
      @(negedge clk);
      link_b.serial_in = bits[i];
      repeat (i == 0 ? 32 : 15) @(negedge link_b.serial_clk);
    end
  endtask
  initial begin
    link_b.serial_in = 1'b1;
    link_b.load_strobe = 1'b1;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    send(1'b0, 16'hA5C3);
    check(dac_value_q, 16'hA5C3);
    send(1'b0, 16'h5A3D);
    check(so_q, 16'hA5C3);
    check(dac_value_q, 16'h5A3D);
    send(1'b1, 16'hC001);
    check(dac_value_q, 16'hC001);
    send(1'b1, 16'h0000);
    check(dac_value_q, 16'h0000);
    near = 1'b1;
    repeat (20) @(negedge clk);
    check({15'h0000, link.loop_fault_n_oe}, 16'h0001);
    near = 1'b0;
    repeat (20) @(negedge clk);
    check({15'h0000, link.loop_fault_n_oe}, 16'h0000);
    repeat (40) @(negedge link_b.serial_clk);
    send_b(16'h3C3C, 1'b1);
    check(dac_b, 16'h3C3C);
    hi_n = 0;
    send_b(16'hC3C3, 1'b0);
    check(hi_n[15:0], 16'h0010);
    check(dac_b, 16'h3C3C);
    send_b(16'h0F0F, 1'b1);
    check(dac_b, 16'h0F0F);
    check(hi_n[15:0], 16'h0010);
    close_out();
  end
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule // tb
